// ===== asr_ctrl.sv
/*
  Host-side controller for a 1M x 1 asynchronous static memory: takes single
  bit read and write requests and sequences address, select, write strobe and
  write data on the memory pins, returning read bits.
  Assumes the read data pin is pulled to a defined level when floated and that
  pin delays are small against the 10 ns clock period.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
  import asr_pkg::*;
#(
  parameter int RD_CYC    = ASR_RD_CYC,
  parameter int PULSE_CYC = ASR_PULSE_CYC
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_SRST,
  input  wire logic       I_REQ_VALID,
  output logic            O_REQ_READY,
  input  wire asr_req_s   I_REQ,
  output logic            O_RSP_VALID,
  output logic            O_RSP_RDATA,
  output asr_pins_s       O_MEM,
  input  wire logic       I_MEM_DOUT
);

  typedef struct packed {
    asr_state_e               state;
    logic [ASR_CNT_W-1:0]     cnt;
    asr_pins_s                pins;
    logic                     rsp_valid;
    logic                     rdata;
    logic [ASR_SYNC_STAGES-1:0] sync;
  } asr_ctrl_s;

  localparam logic [ASR_CNT_W-1:0] RD_LOAD = ASR_CNT_W'(RD_CYC - 1);
  localparam logic [ASR_CNT_W-1:0] WR_LOAD = ASR_CNT_W'(PULSE_CYC - 1);
  localparam logic [ASR_CNT_W-1:0] SU_LOAD = ASR_CNT_W'(asr_max(ASR_WC_CYC - PULSE_CYC, 1) - 1);

  asr_ctrl_s s_reg;
  asr_ctrl_s s_next;

  logic rd_done;
  logic rd_stable;
  logic accept;

  // The read bit is only trusted once the last two synchroniser stages agree.
  assign rd_stable   = (s_reg.sync[1] == s_reg.sync[2]);
  assign rd_done     = (s_reg.state == ASR_RD_WAIT) && (s_reg.cnt == '0) && rd_stable;
  assign O_REQ_READY = (s_reg.state == ASR_IDLE) || rd_done;
  assign accept      = I_REQ_VALID && O_REQ_READY;

  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.sync      = {s_reg.sync[ASR_SYNC_STAGES-2:0], I_MEM_DOUT};
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - ASR_CNT_W'(1);
    end
    unique case (s_reg.state)
      ASR_IDLE: begin
        s_next.pins.ce_n = 1'b1;
        s_next.pins.we_n = 1'b1;
      end
      ASR_RD_WAIT: begin
        if (rd_done) begin
          s_next.rsp_valid = 1'b1;
          s_next.rdata     = s_reg.sync[2];
          s_next.pins.ce_n = 1'b1;
          s_next.state     = ASR_IDLE;
        end
      end
      ASR_WR_SETUP: begin
        if (s_reg.cnt == '0) begin
          // Address and data have been stable for the whole set-up phase.
          s_next.pins.ce_n = 1'b0;
          s_next.pins.we_n = 1'b0;
          s_next.cnt       = WR_LOAD;
          s_next.state     = ASR_WR_PULSE;
        end
      end
      ASR_WR_PULSE: begin
        if (s_reg.cnt == '0) begin
          // Both controls rise on the same edge so the output never turns on.
          s_next.pins.ce_n = 1'b1;
          s_next.pins.we_n = 1'b1;
          s_next.state     = ASR_IDLE;
        end
      end
    endcase
    // A read that follows a read keeps select low and only moves the address.
    if (accept) begin
      s_next.pins.addr = I_REQ.addr;
      s_next.pins.we_n = 1'b1;
      if (I_REQ.write) begin
        s_next.pins.din  = I_REQ.wdata;
        s_next.pins.ce_n = 1'b1;
        s_next.cnt       = SU_LOAD;
        s_next.state     = ASR_WR_SETUP;
      end else begin
        s_next.pins.ce_n = 1'b0;
        s_next.cnt       = RD_LOAD;
        s_next.state     = ASR_RD_WAIT;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      s_reg.state     <= ASR_IDLE;
      s_reg.cnt       <= '0;
      s_reg.pins      <= '{addr: '0, ce_n: 1'b1, we_n: 1'b1, din: 1'b0};
      s_reg.rsp_valid <= 1'b0;
      s_reg.rdata     <= 1'b0;
      s_reg.sync      <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_MEM       = s_reg.pins;
  assign O_RSP_VALID = s_reg.rsp_valid;
  assign O_RSP_RDATA = s_reg.rdata;

  // Assertions on the pin sequencing.
  // The checks below watch the registered pins, state and handshake. The memory itself has no
  // clock, so every timing limit is met by whole clock cycles: the trade is a
  // little throughput for pin timing that holds at any clock-to-pin skew
  // smaller than one period. A slower memory grade needs larger cycle counts through
  // the module parameters and ASR_WC_CYC in the package; the sequencing stays the same.
  wr_overlap_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !O_MEM.we_n |-> !O_MEM.ce_n)
    else $error("Write strobe low without select low.");

  wr_release_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    $fell(O_MEM.we_n) |-> ##1 (O_MEM.we_n && O_MEM.ce_n))
    else $error("Write pulse not released on both controls together.");

  wr_data_hold_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !O_MEM.we_n |=> ($stable(O_MEM.din) && $stable(O_MEM.addr)))
    else $error("Write data or address moved at the end of the write.");

  wr_setup_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    $fell(O_MEM.we_n) |-> ($stable(O_MEM.din) && $stable(O_MEM.addr) && $past(O_MEM.ce_n)))
    else $error("Write started without settled address and data.");

  // While selected the address may only move on the edge that takes a new read,
  // so a read in flight never sees its address slip underneath it.
  rd_addr_first_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (!O_MEM.ce_n && $changed(O_MEM.addr)) |-> $past(accept && !I_REQ.write))
    else $error("Read address moved while a read was in flight.");

  rd_answer_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (accept && !I_REQ.write) |-> ##[1:16] O_RSP_VALID)
    else $error("Read answer did not arrive in time.");

  rd_data_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_RSP_VALID |-> (O_RSP_RDATA == $past(s_reg.sync[2]) && $past(!O_MEM.ce_n && O_MEM.we_n)))
    else $error("Read bit not taken from a selected read.");

  // A read in flight keeps select low and the strobe high until its bit is taken.
  rd_sel_held_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (s_reg.state == ASR_RD_WAIT) |-> (!O_MEM.ce_n && O_MEM.we_n))
    else $error("Select or strobe moved during a read.");

  // Between requests the memory is left deselected so that it drops into standby.
  idle_desel_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (s_reg.state == ASR_IDLE) |-> (O_MEM.ce_n && O_MEM.we_n))
    else $error("Memory left selected while idle.");

  // Address and data must not move during the set-up phase of a write.
  wr_setup_hold_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (s_reg.state == ASR_WR_SETUP) |=> ($stable(O_MEM.din) && $stable(O_MEM.addr)))
    else $error("Write address or data moved during set-up.");

  // The strobe stays low for exactly the configured pulse length.
  wr_pulse_len_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    $rose(O_MEM.we_n) |-> (!$past(O_MEM.we_n, PULSE_CYC) && $past(O_MEM.we_n, PULSE_CYC + 1)))
    else $error("Write pulse length differs from the configured length.");

  // A read answer is a single-cycle pulse.
  rsp_pulse_a: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    O_RSP_VALID |=> !O_RSP_VALID)
    else $error("Read answer held for more than one cycle.");

  // Cover points for the main traffic shapes: a write pulse, a read answer,
  // reads back to back with select held, and a read right after a write.
  wr_cov_c:   cover property (@(posedge I_MCLK) disable iff (I_SRST) $fell(O_MEM.we_n));
  wr_rd_c:    cover property (@(posedge I_MCLK) disable iff (I_SRST)
    ($rose(O_MEM.we_n) ##1 (accept && !I_REQ.write)));
  rd_cov_c:   cover property (@(posedge I_MCLK) disable iff (I_SRST) O_RSP_VALID);
  rd_b2b_c:   cover property (@(posedge I_MCLK) disable iff (I_SRST)
    (rd_done && accept && !I_REQ.write));

endmodule : asr_ctrl
`default_nettype wire

// ===== asr_pkg.sv
/*
  Shared constants, state codes and carriers for the controller of a
  1M x 1 asynchronous static memory.
  Assumes a single 100 MHz system clock and a memory with no clock of its own.
*/
`default_nettype none
package asr_pkg;

  localparam int ASR_ADDR_W  = 20;
  localparam int ASR_DEPTH   = 1048576;
  localparam int ASR_CLK_NS  = 10;

  // Access and write-pulse times of the fastest grade, in ns.
  localparam int ASR_T_AA_NS  = 12;
  localparam int ASR_T_ACE_NS = 12;
  localparam int ASR_T_PWE_NS = 10;
  localparam int ASR_T_SCE_NS = 10;
  localparam int ASR_T_AW_NS  = 10;
  localparam int ASR_T_SD_NS  = 7;
  localparam int ASR_T_WC_NS  = 12;

  function automatic int asr_ceil_cyc(input int ns);
    int c;
    c = (ns + ASR_CLK_NS - 1) / ASR_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : asr_ceil_cyc

  function automatic int asr_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : asr_max

  localparam int ASR_SYNC_STAGES = 3;
  localparam int ASR_AA_CYC      = asr_ceil_cyc(asr_max(ASR_T_AA_NS, ASR_T_ACE_NS));
  localparam int ASR_PULSE_CYC   = asr_ceil_cyc(asr_max(asr_max(ASR_T_PWE_NS, ASR_T_SCE_NS),
                                                        asr_max(ASR_T_AW_NS, ASR_T_SD_NS)));
  localparam int ASR_WC_CYC      = asr_ceil_cyc(ASR_T_WC_NS);
  localparam int ASR_RD_CYC      = ASR_AA_CYC + ASR_SYNC_STAGES;
  localparam int ASR_CNT_W       = 4;

  typedef enum logic [3:0] {
    ASR_IDLE     = 4'h1,
    ASR_RD_WAIT  = 4'h2,
    ASR_WR_SETUP = 4'h4,
    ASR_WR_PULSE = 4'h8
  } asr_state_e;

  typedef struct packed {
    logic                  write;
    logic [ASR_ADDR_W-1:0] addr;
    logic                  wdata;
  } asr_req_s;

  typedef struct packed {
    logic [ASR_ADDR_W-1:0] addr;
    logic                  ce_n;
    logic                  we_n;
    logic                  din;
  } asr_pins_s;

endpackage : asr_pkg
`default_nettype wire

// ===== asr_mem_model.sv
/*
  Behavioural model of the 1M x 1 asynchronous static memory on the far side.
  Assumes the read data line has a pull-up, so a floated pin reads as 1.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model
  import asr_pkg::*;
(
  input  wire asr_pins_s i_pins,
  output logic           o_dout
);
  logic mem [ASR_DEPTH];

  // Only the addressed bit changes, and only during the select and strobe overlap.
  always @* begin
    if (!i_pins.ce_n && !i_pins.we_n) begin
      mem[i_pins.addr] = i_pins.din;
    end
  end

  // Deselected means standby; a floated pin shows the pull-up level, never a stale bit.
  assign o_dout = (!i_pins.ce_n && i_pins.we_n) ? mem[i_pins.addr] : 1'b1;
endmodule : asr_mem_model
`default_nettype wire

// ===== asr_ctrl_test.sv
/*
  Self-checking bench for the memory controller with a memory model behind it.
  Assumes the default read and write-pulse lengths of the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_test;
  import asr_pkg::*;
  logic      clk = 0, rst = 1, vld = 0, rdy, rv, rd, dout;
  asr_req_s  req = '0;
  asr_pins_s pins;
  int        num_errors = 0, n_tests = 0, cyc = 0;

  asr_ctrl DUT (.I_MCLK(clk), .I_SRST(rst), .I_REQ_VALID(vld), .O_REQ_READY(rdy), .I_REQ(req),
                .O_RSP_VALID(rv), .O_RSP_RDATA(rd), .O_MEM(pins), .I_MEM_DOUT(dout));
  asr_mem_model MEM (.i_pins(pins), .o_dout(dout));

  initial forever #5 clk = ~clk;

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // Drives on a rising edge and holds the request up to its take edge; the caller lowers valid.
  task automatic send(input logic w, input logic [19:0] a, input logic d);
    @(posedge clk);
    vld <= 1'b1;
    req <= '{write: w, addr: a, wdata: d};
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
  endtask : send

  task automatic wait_rsp(input logic e);
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      if (rv === 1'b1) break;
    end
    chk(rv === 1'b1 && rd === e, "read answer");
  endtask : wait_rsp

  // The strobe overlap must last the pulse length with address and data held.
  task automatic wr(input logic [19:0] a, input logic d);
    int ov;
    ov = 0;
    send(1'b1, a, d);
    vld <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (pins.ce_n === 1'b0 && pins.we_n === 1'b0) begin
        ov++;
        chk(pins.addr === a && pins.din === d, "write pins");
      end
    end
    chk(ov == ASR_PULSE_CYC, "write overlap length");
  endtask : wr

  task automatic rdx(input logic [19:0] a, input logic e);
    send(1'b0, a, 1'b0);
    vld <= 1'b0;
    wait_rsp(e);
  endtask : rdx

  task automatic t_reset;
    @(negedge clk);
    chk(pins.ce_n === 1'b1 && pins.we_n === 1'b1 && rdy === 1'b1 && rv === 1'b0, "reset state");
  endtask : t_reset

  // Boundary addresses and a neighbour prove one write touches one bit only.
  task automatic t_single;
    wr(20'h00000, 1'b1);
    wr(20'hFFFFF, 1'b0);
    wr(20'h00001, 1'b0);
    rdx(20'h00000, 1'b1);
    rdx(20'hFFFFF, 1'b0);
    rdx(20'h00001, 1'b0);
    wr(20'h00000, 1'b0);
    rdx(20'h00000, 1'b0);
  endtask : t_single

  task automatic t_b2b;
    wr(20'h00002, 1'b1);
    wr(20'h00003, 1'b0);
    send(1'b0, 20'h00002, 1'b0);
    send(1'b0, 20'h00003, 1'b0);
    vld <= 1'b0;
    @(negedge clk);
    chk(pins.ce_n === 1'b0, "select held between reads");
    chk(rv === 1'b1 && rd === 1'b1, "first back-to-back read answer");
    wait_rsp(1'b0);
  endtask : t_b2b

  task automatic summarize;
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_b2b();
    summarize();
  end
endmodule : asr_ctrl_test
`default_nettype wire
